// ===== core/sma_map.svh
/*
  register offsets, field positions, reset values of the shift/move/extend alu.
  assumes byte addresses on an 8-bit register port, one 32-bit word per register.
*/
`ifndef SMA_MAP_SVH
`define SMA_MAP_SVH

`define SMA_ADDR_W       8
`define SMA_FLAGS_OFS    8'h00
`define SMA_CTRL_OFS     8'h04
`define SMA_RESULT_OFS   8'h08
`define SMA_COUNT_OFS    8'h0c

`define SMA_FLAG_V_BIT   0
`define SMA_FLAG_C_BIT   1
`define SMA_FLAG_Z_BIT   2
`define SMA_FLAG_N_BIT   3
`define SMA_CTRL_EN_BIT  0

`define SMA_FLAGS_RST    4'h0
`define SMA_CTRL_RST     1'h1
`define SMA_COUNT_W      16

`endif

// ===== core/sma_pkg.sv
/*
  types shared by the shift/move/extend alu and its bench.
  assumes nothing beyond a systemverilog compiler.
*/
package sma_pkg;

  typedef enum logic [4:0] {
    SMA_OP_LSL   = 5'h00,
    SMA_OP_LSR   = 5'h01,
    SMA_OP_ASR   = 5'h02,
    SMA_OP_ROR   = 5'h03,
    SMA_OP_COMPARE_SUB      = 5'h04,
    SMA_OP_COMPARE_ADD      = 5'h05,
    SMA_OP_COPY             = 5'h06,
    SMA_OP_COPY_FLAGS       = 5'h07,
    SMA_OP_COPY_INV         = 5'h08,
    SMA_OP_MUL              = 5'h09,
    SMA_OP_REVW             = 5'h0a,
    SMA_OP_REVH             = 5'h0b,
    SMA_OP_SWAP_HALF_SIGNED = 5'h0c,
    SMA_OP_SIGN_EXT_BYTE    = 5'h0d,
    SMA_OP_SIGN_EXT_HALF    = 5'h0e,
    SMA_OP_ZERO_EXT_BYTE    = 5'h0f,
    SMA_OP_ZERO_EXT_HALF    = 5'h10,
    SMA_OP_AND_TEST         = 5'h11
  } sma_op_type;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } sma_flags_type;

  typedef struct packed {
    sma_op_type  op;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] shift_amount_reg;
    logic [7:0]  literal_operand;
    logic        imm_sel;
    logic        dest_is_pc;
  } sma_req_type;

  typedef enum logic [1:0] {
    SMA_ST_IDLE = 2'b01,
    SMA_ST_DONE = 2'b10
  } sma_state_type;

endpackage

// ===== core/sma_alu.sv
/*
  shift, compare, move, multiply, byte-swap, extend and test datapath with its
  own condition flags and a small register port.
  assumes the core presents register values already read from its register file,
  one request per cycle, synchronous to clk, and writes the result back itself.
*/
// How it works
// - immediate shift counts: right shifts 1 to 32, left shift 0 to 31.
// - register shift counts use only the low byte of shift_amount_reg.
// - shifts set n,z from result; c is last bit out unless count 0; v kept.
// - flag-setting register copy equals logical left shift by zero.
// - compare_subtract subtracts register or literal, sets nzcv, writes nothing.
// - compare_add adds registers, sets nzcv like an addition, discards the sum.
// - immediate copy_register_flags loads a zero-extended literal 0-255.
// - copy_register touches no flag; copy_register_flags sets n,z only.
// - copy_inverted writes the bitwise complement of the source.
// - copy_register to program_counter branches with bit 0 cleared.
// - multiply_low writes low 32 product bits, sets n,z, keeps c,v.
// - byte_swap_word reverses all four bytes.
// - byte_swap_halves swaps bytes inside each 16-bit half.
// - byte_swap_half_signed swaps low half bytes and sign-extends to 32 bits.
// - byte extensions take bits 7:0, sign or zero filled to 32 bits.
// - halfword extensions take bits 15:0, sign or zero filled to 32 bits.
// - byte-swap and extension operations leave every flag unchanged.
// - and_test ands two registers, sets n,z, writes nothing.
`timescale 1ns/1ns
`include "sma_map.svh"

module sma_alu
  import sma_pkg::*;
#(
  parameter int CLK_HZ = 25000000
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    req_valid,
  input  wire sma_req_type             req,
  output logic                         done,
  output logic [31:0]                  result,
  output logic                         dest_write,
  output logic                         branch,
  output logic [31:0]                  branch_addr,
  output sma_flags_type                flags,
  input  wire logic [`SMA_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata
);

  // write-back decode, used for dest_write only; result word and branch are not gated by it
  function automatic logic fn_writes_dest(input sma_op_type op);
    case (op)
      SMA_OP_COMPARE_SUB,
      SMA_OP_COMPARE_ADD,
      SMA_OP_AND_TEST: fn_writes_dest = 1'b0;
      default:         fn_writes_dest = 1'b1;
    endcase
  endfunction

  // n,z update decode
  function automatic logic fn_sets_nz(input sma_op_type op);
    case (op)
      SMA_OP_COPY,
      SMA_OP_REVW,
      SMA_OP_REVH,
      SMA_OP_SWAP_HALF_SIGNED,
      SMA_OP_SIGN_EXT_BYTE,
      SMA_OP_SIGN_EXT_HALF,
      SMA_OP_ZERO_EXT_BYTE,
      SMA_OP_ZERO_EXT_HALF: fn_sets_nz = 1'b0;
      default:              fn_sets_nz = 1'b1;
    endcase
  endfunction

  sma_state_type        state_reg;
  sma_state_type        state_next;
  sma_flags_type        flags_reg;
  sma_flags_type        flags_next;
  logic                 enable_reg;
  logic [31:0]          result_reg;
  logic [31:0]          result_next;
  logic                 dest_wr_reg;
  logic                 dest_wr_next;
  logic                 branch_reg;
  logic [31:0]          branch_addr_reg;
  logic [`SMA_COUNT_W-1:0] count_reg;
  logic [31:0]          rdata_reg;
  logic                 accept;

  logic [7:0]           shift_cnt;
  logic [63:0]          shl_wide;
  logic [63:0]          shr_wide;
  logic [63:0]          sar_wide;
  logic [63:0]          rot_wide;
  logic [32:0]          sub_wide;
  logic [32:0]          add_wide;
  logic [31:0]          cmp_b;
  logic [63:0]          prod_wide;
  logic [31:0]          rev_word;
  logic [31:0]          rev_half;

  assign accept = req_valid & enable_reg;

  // shift count source
  // immediate or low byte
  assign shift_cnt = req.imm_sel ? req.literal_operand : req.shift_amount_reg[7:0];

  // wide shifters keep the last bit out beside the result word
  // large counts saturate, except rotate, which uses count bits 4:0 only
  assign shl_wide = {32'h0, req.src_a} << shift_cnt;
  assign shr_wide = {req.src_a, 32'h0} >> shift_cnt;
  assign sar_wide = $signed({req.src_a, 32'h0}) >>> shift_cnt;
  assign rot_wide = {req.src_a, req.src_a} >> shift_cnt[4:0];

  assign cmp_b    = req.imm_sel ? {24'h0, req.literal_operand} : req.src_b;
  assign sub_wide = {1'b0, req.src_a} + {1'b0, ~cmp_b} + 33'h1;
  assign add_wide = {1'b0, req.src_a} + {1'b0, req.src_b};

  assign prod_wide = req.src_a * req.src_b;

  // byte reversal networks
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rev
      assign rev_word[8*gi +: 8] = req.src_a[8*(3-gi) +: 8];
      assign rev_half[8*gi +: 8] = req.src_a[8*(gi ^ 1) +: 8];
    end
  endgenerate

  always_comb begin
    result_next  = 32'h0;
    flags_next   = flags_reg;
    dest_wr_next = fn_writes_dest(req.op);
    case (req.op)
      SMA_OP_LSL: begin
        result_next = shl_wide[31:0];
        if (shift_cnt != 8'h0) begin
          flags_next.c = shl_wide[32];
        end
      end
      SMA_OP_LSR: begin
        result_next = shr_wide[63:32];
        if (shift_cnt != 8'h0) begin
          flags_next.c = shr_wide[31];
        end
      end
      SMA_OP_ASR: begin
        result_next = sar_wide[63:32];
        if (shift_cnt != 8'h0) begin
          flags_next.c = sar_wide[31];
        end
      end
      SMA_OP_ROR: begin
        result_next = rot_wide[31:0];
        if (shift_cnt != 8'h0) begin
          flags_next.c = rot_wide[31];
        end
      end
      SMA_OP_COMPARE_SUB: begin
        result_next  = sub_wide[31:0];
        flags_next.c = sub_wide[32];
        flags_next.v = (req.src_a[31] != cmp_b[31]) &&
                       (sub_wide[31] != req.src_a[31]);
      end
      SMA_OP_COMPARE_ADD: begin
        result_next  = add_wide[31:0];
        flags_next.c = add_wide[32];
        flags_next.v = (req.src_a[31] == req.src_b[31]) &&
                       (add_wide[31] != req.src_a[31]);
      end
      SMA_OP_COPY: begin
        result_next = req.src_a;
      end
      SMA_OP_COPY_FLAGS: begin
        // register form same as shift left by zero
        result_next = req.imm_sel ? {24'h0, req.literal_operand} : req.src_a;
      end
      SMA_OP_COPY_INV: begin
        result_next = ~req.src_a;
      end
      SMA_OP_MUL: begin
        result_next = prod_wide[31:0];
      end
      SMA_OP_REVW: begin
        result_next = rev_word;
      end
      SMA_OP_REVH: begin
        result_next = rev_half;
      end
      SMA_OP_SWAP_HALF_SIGNED: begin
        result_next = {{16{rev_half[15]}}, rev_half[15:0]};
      end
      SMA_OP_SIGN_EXT_BYTE: begin
        result_next = {{24{req.src_a[7]}}, req.src_a[7:0]};
      end
      SMA_OP_ZERO_EXT_BYTE: begin
        result_next = {24'h0, req.src_a[7:0]};
      end
      SMA_OP_SIGN_EXT_HALF: begin
        result_next = {{16{req.src_a[15]}}, req.src_a[15:0]};
      end
      SMA_OP_ZERO_EXT_HALF: begin
        result_next = {16'h0, req.src_a[15:0]};
      end
      SMA_OP_AND_TEST: begin
        result_next = req.src_a & req.src_b;
      end
      default: begin
        result_next  = 32'h0;
        dest_wr_next = 1'b0;
      end
    endcase
    if (fn_sets_nz(req.op)) begin
      flags_next.n = result_next[31];
      flags_next.z = (result_next == 32'h0);
    end
  end

  // one-hot handshake state, done is a one-cycle mark
  always_comb begin
    case (state_reg)
      SMA_ST_IDLE: state_next = accept ? SMA_ST_DONE : SMA_ST_IDLE;
      SMA_ST_DONE: state_next = accept ? SMA_ST_DONE : SMA_ST_IDLE;
      default:     state_next = SMA_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= SMA_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // datapath outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg      <= 32'h0;
      dest_wr_reg     <= 1'b0;
      branch_reg      <= 1'b0;
      branch_addr_reg <= 32'h0;
    end else begin
      dest_wr_reg <= 1'b0;
      branch_reg  <= 1'b0;
      if (accept) begin
        result_reg <= result_next;
        // program counter target, bit 0 dropped
        if (req.dest_is_pc && req.op == SMA_OP_COPY) begin
          branch_reg      <= 1'b1;
          branch_addr_reg <= {result_next[31:1], 1'b0};
        end else begin
          dest_wr_reg <= dest_wr_next;
        end
      end
    end
  end

  // flags: an operation beats a same-cycle software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_reg <= `SMA_FLAGS_RST;
    end else if (accept) begin
      flags_reg <= flags_next;
    end else if (reg_wr && reg_addr == `SMA_FLAGS_OFS) begin
      flags_reg.n <= reg_wdata[`SMA_FLAG_N_BIT];
      flags_reg.z <= reg_wdata[`SMA_FLAG_Z_BIT];
      flags_reg.c <= reg_wdata[`SMA_FLAG_C_BIT];
      flags_reg.v <= reg_wdata[`SMA_FLAG_V_BIT];
    end
  end

  // enable gates new requests; a disabled block drops them silently
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg <= `SMA_CTRL_RST;
    end else if (reg_wr && reg_addr == `SMA_CTRL_OFS) begin
      enable_reg <= reg_wdata[`SMA_CTRL_EN_BIT];
    end
  end

  // completed operation count, wraps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (accept) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `SMA_FLAGS_OFS: begin
            rdata_reg[`SMA_FLAG_N_BIT] <= flags_reg.n;
            rdata_reg[`SMA_FLAG_Z_BIT] <= flags_reg.z;
            rdata_reg[`SMA_FLAG_C_BIT] <= flags_reg.c;
            rdata_reg[`SMA_FLAG_V_BIT] <= flags_reg.v;
          end
          `SMA_CTRL_OFS: begin
            rdata_reg[`SMA_CTRL_EN_BIT] <= enable_reg;
          end
          `SMA_RESULT_OFS: begin
            rdata_reg <= result_reg;
          end
          `SMA_COUNT_OFS: begin
            rdata_reg <= {{(32-`SMA_COUNT_W){1'b0}}, count_reg};
          end
          default: begin
            rdata_reg <= 32'h0;
          end
        endcase
      end
    end
  end

  assign done        = state_reg[1];
  assign result      = result_reg;
  assign dest_write  = dest_wr_reg;
  assign branch      = branch_reg;
  assign branch_addr = branch_addr_reg;
  assign flags       = flags_reg;
  assign reg_rdata   = rdata_reg;

endmodule

// ===== sim/sma_alu_assertions.sv
/*
  port-level assertions for sma_alu, bound to every instance.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "sma_map.svh"
module sma_alu_checker
  import sma_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   req_valid,
  input wire sma_req_type            req,
  input wire logic                   done,
  input wire logic [31:0]            result,
  input wire logic                   dest_write,
  input wire logic                   branch,
  input wire logic [31:0]            branch_addr,
  input wire sma_flags_type          flags,
  input wire logic [`SMA_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata
);
  logic [31:0] a_d;
  always_ff @(posedge clk) begin
    a_d <= req.src_a;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_branch_addr_even: assert property (
    branch |-> branch_addr == {result[31:1], 1'b0})
    else $error("branch address not the result with bit 0 cleared");
  a_branch_from_copy: assert property (
    branch |-> $past(req.op) == SMA_OP_COPY && $past(req.dest_is_pc) && !dest_write)
    else $error("branch without a copy to the program counter");
  a_compare_no_write: assert property (
    done && $past(req.op) inside {SMA_OP_COMPARE_SUB, SMA_OP_COMPARE_ADD, SMA_OP_AND_TEST}
    |-> !dest_write)
    else $error("compare or test wrote a destination");
  a_copy_keeps_flags: assert property (
    done && $past(req.op) == SMA_OP_COPY |-> $stable(flags))
    else $error("plain copy changed the flags");
  a_swap_keeps_flags: assert property (
    done && $past(req.op) inside {[SMA_OP_REVW:SMA_OP_ZERO_EXT_HALF]}
    |-> flags == $past(flags))
    else $error("swap or extend changed the flags");
  a_shift_keeps_v: assert property (
    done && $past(req.op) inside {[SMA_OP_LSL:SMA_OP_ROR]} |-> flags.v == $past(flags.v))
    else $error("shift changed overflow");
  a_mul_low_word: assert property (
    done && $past(req.op) == SMA_OP_MUL
    |-> result == $past(req.src_a) * $past(req.src_b) && flags[1:0] == $past(flags[1:0]))
    else $error("multiply result or carry/overflow wrong");
  a_nz_from_result: assert property (
    done && $past(req.op) inside {[SMA_OP_LSL:SMA_OP_COMPARE_ADD],
    [SMA_OP_COPY_FLAGS:SMA_OP_MUL], SMA_OP_AND_TEST}
    |-> flags.z == (result == 32'h0) && flags.n == result[31])
    else $error("n or z not taken from the result");
  a_rev_word_order: assert property (
    done && $past(req.op) == SMA_OP_REVW
    |-> result == {a_d[7:0], a_d[15:8], a_d[23:16], a_d[31:24]})
    else $error("word byte reversal wrong");
endmodule

bind sma_alu sma_alu_checker u_chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
  .req(req), .done(done), .result(result), .dest_write(dest_write), .branch(branch),
  .branch_addr(branch_addr), .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ===== sim/sma_alu_tb.sv
/*
  self-checking bench of sma_alu: corner and random requests, register port.
  assumes the package and the map header are compiled first.
*/
`timescale 1ns/1ns
`include "sma_map.svh"
module sma_alu_tb
  import sma_pkg::*;
;
  typedef struct packed {logic [31:0] r; sma_flags_type f; logic dw; logic br;} sma_exp_type;
  logic                   clk, rst_n, req_valid, reg_wr, reg_rd, done, dest_write, branch;
  logic                   rd_d = 1'b0;
  sma_req_type            req, q;
  sma_flags_type          flags, ef;
  logic [31:0]            result, branch_addr, reg_wdata, reg_rdata, lr;
  logic [`SMA_ADDR_W-1:0] reg_addr;
  sma_exp_type            eq[$], m;
  logic [31:0]            rq[$];
  int                     mismatches, checked, acc, cyc;
  int                     cnts[7] = '{0, 1, 31, 32, 33, 64, 255};

  sma_alu DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .done(done),
    .result(result), .dest_write(dest_write), .branch(branch), .branch_addr(branch_addr),
    .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic compare_op(input logic [31:0] got, input logic [31:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic compare_read(input logic [31:0] got, input logic [31:0] exp);
    compare_op(got, exp, "register read");
  endtask

  // reference: flags carried across ops, count 0 keeps carry
  function automatic void model(input sma_req_type q, inout sma_flags_type f,
                                output sma_exp_type e);
    logic [63:0] u;
    logic [32:0] t;
    logic [31:0] a, b, r;
    logic [7:0]  n;
    a = q.src_a;
    n = q.imm_sel ? q.literal_operand : q.shift_amount_reg[7:0];
    b = q.imm_sel ? {24'h0, q.literal_operand} : q.src_b;
    e.dw = 1'b1;
    e.br = 1'b0;
    r = a;
    case (q.op)
      SMA_OP_LSL: begin u = {32'h0, a} << n; r = u[31:0]; if (n != 0) f.c = u[32]; end
      SMA_OP_LSR: begin t = {a, 1'b0} >> n; r = t[32:1]; if (n != 0) f.c = t[0]; end
      SMA_OP_ASR: begin
        t = $signed({a, 1'b0}) >>> (n > 33 ? 33 : n);
        r = t[32:1];
        if (n != 0) f.c = t[0];
      end
      SMA_OP_ROR: begin
        r = (a >> n[4:0]) | (a << (6'd32 - {1'b0, n[4:0]}));
        if (n != 0) f.c = r[31];
      end
      SMA_OP_COMPARE_SUB: begin
        t = {1'b0, a} + {1'b0, ~b} + 33'h1;
        r = t[31:0];
        f.c = t[32];
        f.v = (a[31] != b[31]) && (r[31] != a[31]);
        e.dw = 1'b0;
      end
      SMA_OP_COMPARE_ADD: begin
        t = {1'b0, a} + {1'b0, q.src_b};
        r = t[31:0];
        f.c = t[32];
        f.v = (a[31] == q.src_b[31]) && (r[31] != a[31]);
        e.dw = 1'b0;
      end
      SMA_OP_COPY: begin e.dw = !q.dest_is_pc; e.br = q.dest_is_pc; end
      SMA_OP_COPY_FLAGS: r = q.imm_sel ? b : a;
      SMA_OP_COPY_INV: r = ~a;
      SMA_OP_MUL: r = a * q.src_b;
      SMA_OP_REVW: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      SMA_OP_REVH: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      SMA_OP_SWAP_HALF_SIGNED: r = {{16{a[7]}}, a[7:0], a[15:8]};
      SMA_OP_SIGN_EXT_BYTE: r = {{24{a[7]}}, a[7:0]};
      SMA_OP_SIGN_EXT_HALF: r = {{16{a[15]}}, a[15:0]};
      SMA_OP_ZERO_EXT_BYTE: r = {24'h0, a[7:0]};
      SMA_OP_ZERO_EXT_HALF: r = {16'h0, a[15:0]};
      default: begin r = a & q.src_b; e.dw = 1'b0; end
    endcase
    if (!(q.op inside {SMA_OP_COPY, [SMA_OP_REVW:SMA_OP_ZERO_EXT_HALF]})) begin
      f.n = r[31];
      f.z = (r == 32'h0);
    end
    e.r = r;
    e.f = f;
  endfunction

  task automatic send(input logic ok);
    sma_exp_type e;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= q;
    if (ok) begin
      model(q, ef, e);
      eq.push_back(e);
      lr = e.r;
      acc++;
    end
  endtask

  task automatic idle();
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(d);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // results are taken off the queue as they appear
  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1 && eq.size() == 0) compare_op(32'h1, 32'h0, "done without request");
    else if (done === 1'b1) begin
      m = eq.pop_front();
      compare_op(result, m.r, "result");
      compare_op(32'(flags), 32'(m.f), "flags");
      compare_op(32'(dest_write), 32'(m.dw), "dest_write");
      compare_op(32'(branch), 32'(m.br), "branch");
      if (m.br) compare_op(branch_addr, {m.r[31:1], 1'b0}, "branch address");
    end
    if (rd_d) compare_read(reg_rdata, rq.pop_front());
    rd_d <= reg_rd;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    q = '0;
    ef = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(31));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SMA_FLAGS_OFS, 32'h0);
    rd(`SMA_CTRL_OFS, 32'h1);
    rd(`SMA_COUNT_OFS, 32'h0);
    rd(`SMA_RESULT_OFS, 32'h0);
    rd(8'h10, 32'h0);
    $display("reset values done");
    // count corners, upper count bytes ignored
    for (int o = 0; o < 4; o++) begin
      for (int k = 0; k < 7; k++) begin
        q = '0;
        q.op = sma_op_type'(o);
        q.src_a = 32'h8000_0001;
        q.shift_amount_reg = {24'h5a5a01, 8'(cnts[k])};
        send(1'b1);
      end
    end
    $display("count corners done");
    // literals kept in their legal ranges
    for (int i = 0; i < 400; i++) begin
      q.op = sma_op_type'($urandom_range(0, 17));
      q.src_a = (i % 16 == 0) ? 32'h0 : $urandom;
      q.src_b = $urandom;
      q.shift_amount_reg = $urandom;
      if (i % 2) q.shift_amount_reg[7:0] = 8'($urandom_range(0, 40));
      q.imm_sel = (q.op inside {SMA_OP_LSL, SMA_OP_LSR, SMA_OP_ASR, SMA_OP_COMPARE_SUB,
                                SMA_OP_COPY_FLAGS}) ? 1'($urandom) : 1'b0;
      q.literal_operand = q.op == SMA_OP_LSL ? 8'($urandom_range(0, 31)) :
        q.op inside {SMA_OP_LSR, SMA_OP_ASR} ? 8'($urandom_range(1, 32)) : 8'($urandom);
      q.dest_is_pc = ($urandom_range(0, 7) == 0);
      send(1'b1);
      if ($urandom_range(0, 3) == 0) idle();
    end
    idle();
    $display("random requests done");
    wr(`SMA_CTRL_OFS, 32'h0);
    send(1'b0);
    send(1'b0);
    idle();
    wr(`SMA_CTRL_OFS, 32'h1);
    rd(`SMA_COUNT_OFS, 32'(acc[15:0]));
    $display("refusal done");
    wr(`SMA_FLAGS_OFS, 32'ha);
    ef = 4'ha;
    rd(`SMA_FLAGS_OFS, 32'ha);
    q.op = SMA_OP_COPY;
    q.src_a = 32'h1234_5677;
    q.dest_is_pc = 1'b1;
    send(1'b1);
    q.dest_is_pc = 1'b0;
    send(1'b1);
    q.op = SMA_OP_SIGN_EXT_BYTE;
    send(1'b1);
    idle();
    rd(`SMA_RESULT_OFS, lr);
    rd(`SMA_FLAGS_OFS, 32'ha);
    repeat (3) @(posedge clk);
    compare_op(32'(eq.size()), 32'h0, "requests left unanswered");
    $display("register port done");
    print_verdict();
  end
endmodule
